// ===== rtl/bmx_pkg.sv
package bmx_pkg;
   localparam int BMX_MASTERS = 16;
   localparam int BMX_SLAVES = 16;
   localparam int BMX_IDX_W = 4;
   localparam int BMX_KIND_W = 2;
   localparam int BMX_PRIO_W = 2;
   localparam int BMX_SFR_W = 32;
   // default master kind encodings
   localparam logic [1:0] BMX_KIND_NONE = 2'h0;
   localparam logic [1:0] BMX_KIND_LAST = 2'h1;
   localparam logic [1:0] BMX_KIND_FIXED = 2'h2;
   // arbitration type encodings
   localparam logic BMX_ARB_RR = 1'h0;
   localparam logic BMX_ARB_PRIO = 1'h1;
   // reset values and connection latency
   localparam logic [1:0] BMX_KIND_RST = 2'h0;
   localparam logic [3:0] BMX_FIXED_RST = 4'h0;
   localparam logic [31:0] BMX_SFR_RST = 32'h0;
   localparam int BMX_CONNECT_LAT = 1;
endpackage

// ===== rtl/bmx_matrix.sv
`timescale 1ns/1ns
module bmx_matrix
   import bmx_pkg::*;
#(
   parameter int N_MASTERS = 16,
   parameter int N_SLAVES = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // master request side
   input wire logic [N_MASTERS-1:0] mst_req,
   input wire logic [N_MASTERS-1:0][bmx_pkg::BMX_IDX_W-1:0] mst_slave_sel,
   input wire logic [N_MASTERS-1:0] mst_last,
   output logic [N_MASTERS-1:0] mst_ready,
   // slave side routing
   output logic [N_SLAVES-1:0] slv_active,
   output logic [N_SLAVES-1:0][bmx_pkg::BMX_IDX_W-1:0] slv_master,
   output logic [N_SLAVES-1:0] slv_connected,
   // configuration port
   input wire logic cfg_clk_en,
   input wire logic cfg_wr,
   input wire logic cfg_sfr_sel,
   input wire logic [bmx_pkg::BMX_IDX_W-1:0] cfg_slave,
   input wire logic [bmx_pkg::BMX_SFR_W-1:0] cfg_wdata,
   input wire logic [N_SLAVES-1:0] cfg_arb_type,
   input wire logic [N_SLAVES-1:0][N_MASTERS-1:0][bmx_pkg::BMX_PRIO_W-1:0] cfg_prio,
   output logic [bmx_pkg::BMX_SFR_W-1:0] cfg_rdata
);
   import bmx_pkg::*;

   typedef struct packed {
      logic [N_SLAVES-1:0] conn;
      logic [N_SLAVES-1:0] busy;
      logic [N_SLAVES-1:0][BMX_IDX_W-1:0] owner;
      logic [N_SLAVES-1:0][BMX_IDX_W-1:0] rr_ptr;
      logic [N_SLAVES-1:0][BMX_KIND_W-1:0] kind;
      logic [N_SLAVES-1:0][BMX_IDX_W-1:0] fixed_idx;
      logic [N_SLAVES-1:0][BMX_KIND_W-1:0] kind_pend;
      logic [N_SLAVES-1:0][BMX_IDX_W-1:0] fixed_pend;
      logic [N_SLAVES-1:0][BMX_SFR_W-1:0] slave_special_function_register;
      logic [BMX_SFR_W-1:0] rdata;
   } bmx_state_t;

   bmx_state_t st_ff, nxt_st;

   // requests of every master aimed at slave s
   function automatic logic [N_MASTERS-1:0] bmx_req_for(input logic [3:0] s,
         input logic [N_MASTERS-1:0] req,
         input logic [N_MASTERS-1:0][BMX_IDX_W-1:0] sel);
      logic [N_MASTERS-1:0] r;
      r = '0;
      for (int m = 0; m < N_MASTERS; m++) begin
         r[m] = req[m] && (sel[m] == s);
      end
      return r;
   endfunction

   // round-robin pick starting after pointer
   function automatic logic [BMX_IDX_W-1:0] bmx_rr_pick(input logic [N_MASTERS-1:0] r,
         input logic [BMX_IDX_W-1:0] ptr);
      logic [BMX_IDX_W-1:0] w;
      logic found;
      logic [BMX_IDX_W-1:0] idx;
      w = '0;
      found = 1'b0;
      for (int k = 1; k <= N_MASTERS; k++) begin
         idx = BMX_IDX_W'((int'(ptr) + k) % N_MASTERS);
         if (!found && r[idx]) begin
            w = idx;
            found = 1'b1;
         end
      end
      return w;
   endfunction

   // priority pick, ties to highest index
   function automatic logic [BMX_IDX_W-1:0] bmx_prio_pick(input logic [N_MASTERS-1:0] r,
         input logic [N_MASTERS-1:0][BMX_PRIO_W-1:0] pr);
      logic [BMX_IDX_W-1:0] w;
      logic [BMX_PRIO_W-1:0] best;
      logic found;
      w = '0;
      best = '0;
      found = 1'b0;
      for (int m = 0; m < N_MASTERS; m++) begin
         if (r[m] && (!found || pr[m] >= best)) begin
            w = BMX_IDX_W'(m);
            best = pr[m];
            found = 1'b1;
         end
      end
      return w;
   endfunction

   // true when w requests and no requester outranks it
   function automatic logic bmx_rank_ok(input logic [N_MASTERS-1:0] r,
         input logic [N_MASTERS-1:0][BMX_PRIO_W-1:0] pr,
         input logic [BMX_IDX_W-1:0] w);
      logic ok;
      ok = r[w];
      for (int m = 0; m < N_MASTERS; m++) begin
         if (r[m] && (pr[m] > pr[w] || (pr[m] == pr[w] && m > int'(w)))) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // true when w requests and no lower index requests
   function automatic logic bmx_lowest_ok(input logic [N_MASTERS-1:0] r,
         input logic [BMX_IDX_W-1:0] w);
      logic ok;
      ok = r[w];
      for (int m = 0; m < N_MASTERS; m++) begin
         if (r[m] && m < int'(w)) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   logic [N_SLAVES-1:0][N_MASTERS-1:0] req_s;
   logic [N_MASTERS-1:0] ready_c;

   always_comb begin
      logic [BMX_IDX_W-1:0] win;
      logic [BMX_IDX_W-1:0] own;
      win = '0;
      own = '0;
      nxt_st = st_ff;
      ready_c = '0;
      for (int s = 0; s < N_SLAVES; s++) begin
         req_s[s] = bmx_req_for(4'(s), mst_req, mst_slave_sel);
      end
      for (int s = 0; s < N_SLAVES; s++) begin
         own = st_ff.owner[s];
         if (st_ff.busy[s]) begin
            // transfer in progress; no re-arbitration before its end
            if (req_s[s][own]) begin
               ready_c[own] = 1'b1;
               if (mst_last[own]) begin
                  nxt_st.busy[s] = 1'b0;
               end
            end else begin
               nxt_st.busy[s] = 1'b0;
            end
         end else if (req_s[s] != '0) begin
            if (st_ff.conn[s] && req_s[s][own]) begin
               // already connected master proceeds at once
               ready_c[own] = 1'b1;
               nxt_st.busy[s] = !mst_last[own];
            end else begin
               if (cfg_arb_type[s] == BMX_ARB_PRIO) begin
                  win = bmx_prio_pick(req_s[s], cfg_prio[s]);
               end else begin
                  // pointer resets to last index so master 0 leads
                  win = bmx_rr_pick(req_s[s], st_ff.rr_ptr[s]);
                  nxt_st.rr_ptr[s] = win;
               end
               // connect now, data phase next cycle
               nxt_st.conn[s] = 1'b1;
               nxt_st.owner[s] = win;
            end
         end else begin
            // idle: apply pending config, then default master policy
            nxt_st.kind[s] = st_ff.kind_pend[s];
            nxt_st.fixed_idx[s] = st_ff.fixed_pend[s];
            unique case (st_ff.kind_pend[s])
               BMX_KIND_LAST: nxt_st.conn[s] = st_ff.conn[s];
               BMX_KIND_FIXED: begin
                  nxt_st.conn[s] = 1'b1;
                  nxt_st.owner[s] = st_ff.fixed_pend[s];
               end
               default: nxt_st.conn[s] = 1'b0;
            endcase
         end
      end
      // configuration writes only while interface clock enabled
      if (cfg_clk_en && cfg_wr) begin
         if (cfg_sfr_sel) begin
            nxt_st.slave_special_function_register[cfg_slave] = cfg_wdata;
         end else begin
            nxt_st.kind_pend[cfg_slave] = cfg_wdata[1:0];
            nxt_st.fixed_pend[cfg_slave] = cfg_wdata[7:4];
         end
      end
      if (cfg_clk_en) begin
         nxt_st.rdata = cfg_sfr_sel ? st_ff.slave_special_function_register[cfg_slave] :
            {24'h0, st_ff.fixed_pend[cfg_slave], 2'h0, st_ff.kind_pend[cfg_slave]};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff.conn <= '0;
         st_ff.busy <= '0;
         st_ff.owner <= '0;
         st_ff.rr_ptr <= '1;
         st_ff.kind <= {N_SLAVES{BMX_KIND_RST}};
         st_ff.fixed_idx <= {N_SLAVES{BMX_FIXED_RST}};
         st_ff.kind_pend <= {N_SLAVES{BMX_KIND_RST}};
         st_ff.fixed_pend <= {N_SLAVES{BMX_FIXED_RST}};
         st_ff.slave_special_function_register <= {N_SLAVES{BMX_SFR_RST}};
         st_ff.rdata <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mst_ready = ready_c;
   assign slv_connected = st_ff.conn;
   assign slv_master = st_ff.owner;
   assign cfg_rdata = st_ff.rdata;

   genvar gs;
   genvar gm;
   generate
      for (gs = 0; gs < N_SLAVES; gs++) begin : g_act
         assign slv_active[gs] = st_ff.conn[gs] && req_s[gs][st_ff.owner[gs]];
      end
   endgenerate

   // assertions, one set per slave so every routed layer is watched
   for (gs = 0; gs < N_SLAVES; gs++) begin : g_chk
      logic arb_now;
      // arbitration cycle: idle slave, request not from the connected master
      assign arb_now = !st_ff.busy[gs] && req_s[gs] != '0
         && !(st_ff.conn[gs] && req_s[gs][st_ff.owner[gs]]);
      new_conn_lat_a: assert property (@(posedge clk) disable iff (reset)
         (!st_ff.conn[gs] && req_s[gs] != '0 && !st_ff.busy[gs]) |-> ##1 st_ff.conn[gs])
         else $error("new connection not made in one cycle");
      dflt_zero_a: assert property (@(posedge clk) disable iff (reset)
         (st_ff.conn[gs] && !st_ff.busy[gs] && req_s[gs][st_ff.owner[gs]]) |->
         mst_ready[st_ff.owner[gs]])
         else $error("default master delayed");
      none_disc_a: assert property (@(posedge clk) disable iff (reset)
         (!st_ff.busy[gs] && req_s[gs] == '0 && st_ff.kind_pend[gs] == BMX_KIND_NONE)
         |=> !st_ff.conn[gs])
         else $error("slave not disconnected in no-default kind");
      last_keep_a: assert property (@(posedge clk) disable iff (reset)
         (!st_ff.busy[gs] && req_s[gs] == '0 && st_ff.kind_pend[gs] == BMX_KIND_LAST)
         |=> $stable(st_ff.owner[gs]) && $stable(st_ff.conn[gs]))
         else $error("last master lost");
      fixed_conn_a: assert property (@(posedge clk) disable iff (reset)
         (!st_ff.busy[gs] && req_s[gs] == '0 && st_ff.kind_pend[gs] == BMX_KIND_FIXED)
         |=> st_ff.conn[gs] && st_ff.owner[gs] == $past(st_ff.fixed_pend[gs]))
         else $error("fixed master not connected");
      busy_hold_a: assert property (@(posedge clk) disable iff (reset)
         st_ff.busy[gs] |=> $stable(st_ff.kind[gs]) && $stable(st_ff.owner[gs]))
         else $error("config applied during access");
      cfg_apply_a: assert property (@(posedge clk) disable iff (reset)
         (st_ff.busy[gs] || req_s[gs] != '0) |=> $stable(st_ff.kind[gs])
         && $stable(st_ff.fixed_idx[gs]))
         else $error("config applied while slave in use");
      prio_win_a: assert property (@(posedge clk) disable iff (reset)
         (arb_now && cfg_arb_type[gs] == BMX_ARB_PRIO) |=>
         bmx_rank_ok($past(req_s[gs]), $past(cfg_prio[gs]), st_ff.owner[gs]))
         else $error("priority winner wrong");
      rr_first_a: assert property (@(posedge clk) disable iff (reset)
         (arb_now && cfg_arb_type[gs] == BMX_ARB_RR && st_ff.rr_ptr[gs] == '1) |=>
         bmx_lowest_ok($past(req_s[gs]), st_ff.owner[gs]))
         else $error("round-robin did not start at lowest master");
   end

   // a master only sees ready from the slave that it owns
   for (gm = 0; gm < N_MASTERS; gm++) begin : g_mchk
      single_ready_a: assert property (@(posedge clk) disable iff (reset)
         mst_ready[gm] |-> mst_req[gm] && st_ff.conn[mst_slave_sel[gm]]
         && st_ff.owner[mst_slave_sel[gm]] == BMX_IDX_W'(gm))
         else $error("ready to a master that does not own the slave");
   end

   cfg_gate_a: assert property (@(posedge clk) disable iff (reset)
      !cfg_clk_en |=> $stable(st_ff.kind_pend) && $stable(st_ff.slave_special_function_register))
      else $error("config changed with clock disabled");
   cfg_rd_hold_a: assert property (@(posedge clk) disable iff (reset)
      !cfg_clk_en |=> $stable(st_ff.rdata))
      else $error("read data changed with clock disabled");
   cov_conn_c: cover property (@(posedge clk) disable iff (reset)
      !st_ff.conn[2] ##1 st_ff.conn[2]);
   cov_burst_c: cover property (@(posedge clk) disable iff (reset)
      st_ff.busy[2] ##1 !st_ff.busy[2]);
   cov_fixed_c: cover property (@(posedge clk) disable iff (reset)
      st_ff.kind[4] == BMX_KIND_FIXED && mst_ready[st_ff.owner[4]]);
   cov_prio_c: cover property (@(posedge clk) disable iff (reset)
      cfg_arb_type[11] && st_ff.conn[11] && mst_ready[st_ff.owner[11]]);
endmodule // bmx_matrix

// ===== verif/bmx_mst_model.sv
`timescale 1ns/1ns
// one bus master on the data side only; configuration is never touched here
module bmx_mst_model (
   // clock
   input wire logic clk,
   // command from bench
   input wire logic go,
   input wire logic [3:0] tgt,
   input wire logic [3:0] beats,
   // bus side
   input wire logic ready,
   output logic req,
   output logic [3:0] sel,
   output logic last
);
   logic [3:0] left;
   logic took;
   initial begin
      req = 1'b0;
      sel = 4'h0;
      last = 1'b0;
      left = 4'h0;
      took = 1'b0;
   end
   always @(posedge clk) took = req & ready;
   always @(negedge clk) begin
      if (go && !req) begin
         req <= 1'b1;
         sel <= tgt;
         left <= beats;
         last <= (beats == 4'h1);
      end else if (req && took && left == 4'h1) begin
         req <= 1'b0;
         last <= 1'b0;
         sel <= ~sel;
      end else if (req && took) begin
         left <= left - 4'h1;
         last <= (left == 4'h2);
      end else if (!req) begin
         sel <= ~sel;
      end
   end
endmodule // bmx_mst_model

// ===== verif/tb_bmx_matrix.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_bmx_matrix;
   import bmx_pkg::*;
   logic clk, reset, cfg_clk_en, cfg_wr, cfg_sfr_sel;
   wire [15:0] mreq, mlast, mrdy, act, conn;
   logic [15:0] go, arb, fst;
   wire [15:0][3:0] msel, smst;
   logic [15:0][3:0] tgt, nb;
   logic [15:0][15:0][1:0] prio;
   logic [3:0] cfg_slave;
   wire [31:0] rdata;
   logic [31:0] wdata, seed;
   logic [11:0] e;
   logic [7:0] wt [16];
   logic [11:0] expq [$];
   int err_total, check_count;
   bmx_matrix bmx_matrix_i (.clk(clk), .reset(reset), .mst_req(mreq), .mst_slave_sel(msel),
      .mst_last(mlast), .mst_ready(mrdy), .slv_active(act), .slv_master(smst),
      .slv_connected(conn), .cfg_clk_en(cfg_clk_en), .cfg_wr(cfg_wr),
      .cfg_sfr_sel(cfg_sfr_sel), .cfg_slave(cfg_slave), .cfg_wdata(wdata),
      .cfg_arb_type(arb), .cfg_prio(prio), .cfg_rdata(rdata));
   for (genvar m = 0; m < 16; m++) begin : g_mst
      bmx_mst_model bmx_mst_model_i (.clk(clk), .go(go[m]), .tgt(tgt[m]), .beats(nb[m]),
         .ready(mrdy[m]), .req(mreq[m]), .sel(msel[m]), .last(mlast[m]));
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic issue(input int m, input logic [3:0] s, n, input logic [7:0] lat);
      go[m] <= 1'b1;
      tgt[m] <= s;
      nb[m] <= n;
      expq.push_back({m[3:0], lat});
   endtask
   task automatic run();
      @(negedge clk);
      go <= '0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 50 && mreq !== 16'h0; i++) @(negedge clk);
      repeat (2) @(negedge clk);
   endtask
   task automatic xfer(input int m, input logic [3:0] s, n, input logic [7:0] lat);
      @(negedge clk);
      issue(m, s, n, lat);
      run();
   endtask
   task automatic cfgw(input logic slave_special_function_register, en, input logic [3:0] s, input logic [31:0] d);
      @(negedge clk);
      cfg_wr <= 1'b1;
      cfg_sfr_sel <= slave_special_function_register;
      cfg_clk_en <= en;
      cfg_slave <= s;
      wdata <= d;
      @(negedge clk);
      cfg_wr <= 1'b0;
      cfg_clk_en <= 1'b1;
      repeat (2) @(negedge clk);
   endtask
   task automatic cfgr(input logic slave_special_function_register, input logic [3:0] s, input logic [31:0] x);
      @(negedge clk);
      cfg_sfr_sel <= slave_special_function_register;
      cfg_slave <= s;
      repeat (2) @(negedge clk);
      `CHK(rdata, x)
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // first accepted beat of each transfer against the oldest note
   always @(posedge clk) begin
      for (int m = 0; m < 16; m++) begin
         if (mreq[m] !== 1'b1) begin
            fst[m] = 1'b1;
            wt[m] = 8'h0;
         end else if (fst[m] && mrdy[m] === 1'b1) begin
            fst[m] = 1'b0;
            e = (expq.size() > 0) ? expq.pop_front() : 12'hfff;
            `CHK(m[3:0], e[11:8])
            `CHK({act[msel[m]], smst[msel[m]]}, {1'b1, m[3:0]})
            if (e[7:0] != 8'hff) `CHK(wt[m], e[7:0])
         end else if (fst[m]) begin
            wt[m]++;
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #20000;
      err_total++;
      end_sim();
   end
   initial begin
      {reset, cfg_clk_en, cfg_wr, cfg_sfr_sel, go, tgt, nb, arb, prio} = '0;
      {reset, cfg_clk_en, cfg_slave, wdata, seed} = {2'h3, 4'h0, 32'h0, 32'h8e27};
      {fst, err_total, check_count} = '1;
      {err_total, check_count} = '0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset <= 1'b0;
      xfer(3, 4'h2, 4'h1, 8'h1);
      xfer(3, 4'h2, 4'h1, 8'h1);
      `CHK(conn[2], 1'b0)
      $display("test no_default end");
      cfgw(1'b0, 1'b1, 4'h2, 32'h1);
      xfer(3, 4'h2, 4'h1, 8'h1);
      xfer(3, 4'h2, 4'h1, 8'h0);
      `CHK({conn[2], smst[2]}, 5'h13)
      xfer(3, 4'h2, 4'h4, 8'h0);
      xfer(5, 4'h2, 4'h1, 8'h1);
      $display("test last_master end");
      cfgw(1'b0, 1'b1, 4'h4, 32'h72);
      xfer(7, 4'h4, 4'h1, 8'h0);
      xfer(6, 4'h4, 4'h1, 8'h1);
      xfer(7, 4'h4, 4'h1, 8'h0);
      cfgw(1'b0, 1'b0, 4'h4, 32'h92);
      xfer(7, 4'h4, 4'h1, 8'h0);
      cfgr(1'b0, 4'h4, 32'h72);
      cfgr(1'b0, 4'h2, 32'h1);
      $display("test fixed_master end");
      @(negedge clk);
      issue(0, 4'h8, 4'h1, 8'h1);
      issue(1, 4'h9, 4'h1, 8'h1);
      run();
      @(negedge clk);
      issue(2, 4'ha, 4'h1, 8'h1);
      issue(5, 4'ha, 4'h1, 8'h3);
      run();
      arb[11] <= 1'b1;
      @(negedge clk);
      issue(9, 4'hb, 4'h1, 8'h1);
      issue(4, 4'hb, 4'h1, 8'h3);
      run();
      prio[11][4] <= 2'h3;
      @(negedge clk);
      issue(4, 4'hb, 4'h1, 8'h1);
      issue(9, 4'hb, 4'h1, 8'h3);
      run();
      $display("test arbitration end");
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         cfgw(1'b1, 1'b1, seed[3:0], seed);
         cfgw(1'b1, 1'b0, seed[3:0], ~seed);
         cfgr(1'b1, seed[3:0], seed);
      end
      `CHK(expq.size(), 0)
      $display("test special_regs end");
      end_sim();
   end
endmodule // tb_bmx_matrix
